/* File: logic/cond_branch_pkg.sv */
package cond_branch_pkg;

  // program counter and displacement geometry
  localparam int PC_W = 12;
  localparam int DISP_W = 7;
  localparam int EXT_W = PC_W - DISP_W;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [PC_W-1:0] PC_ONE = 12'h001;

  // cycle figures for the two outcomes
  localparam int CYCLES_NOT_TAKEN = 1;
  localparam int CYCLES_TAKEN = 2;

  // branch kinds that the fetch logic hands over
  typedef enum logic [3:0] {
    branch_if_positive,
    branch_if_signed_ge,
    branch_if_signed_lt,
    branch_if_halfcarry_set,
    branch_if_halfcarry_clear,
    branch_if_transfer_set,
    branch_if_transfer_clear,
    branch_if_overflow_set,
    branch_if_overflow_clear,
    branch_none
  } branch_kind_t;

  // instruction as presented by the fetch logic
  typedef struct packed {
    branch_kind_t kind;
    logic [DISP_W-1:0] disp;
  } branch_instr_t;

  // status flags the branches test
  typedef struct packed {
    logic halfcarry;
    logic transfer;
    logic negative;
    logic overflow;
  } branch_flags_t;

  // completion report
  typedef struct packed {
    logic done;
    logic taken;
  } branch_result_t;

endpackage

/* File: logic/cond_branch_eval.sv */
`timescale 1ns/1ns
// Behaviour
// - positive branch taken only when negative clear
// - taken branch: pc plus displacement plus one
// - signed ge taken when negative xor overflow 0
// - signed lt taken when negative xor overflow 1
// - halfcarry set branch taken when halfcarry 1
// - halfcarry clear branch taken when halfcarry 0
// - transfer branches follow transfer flag 1/0
// - overflow branches follow overflow flag 1/0
// - no branch ever writes any status flag
module cond_branch_eval
  import cond_branch_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire branch_instr_t i_instr,
  input wire branch_flags_t i_flags,
  output logic o_ready,
  output logic [PC_W-1:0] o_pc,
  output branch_result_t o_result,
  output logic o_flags_we
);

  // sequencing states: idle takes new work, taken spends the second cycle
  typedef enum logic {
    st_idle,
    st_taken
  } state_t;

  // every code the kind field can carry, named or not
  localparam int KIND_CODES = 2 ** $bits(branch_kind_t);

  // condition of one branch kind against the given flags
  function automatic logic cond_holds(input branch_kind_t kind, input branch_flags_t f);
    logic sign_lt;
    sign_lt = f.negative ^ f.overflow;
    case (kind)
      branch_if_positive: begin
        cond_holds = (f.negative == 1'h0);
      end
      branch_if_signed_ge: begin
        cond_holds = (sign_lt == 1'h0);
      end
      branch_if_signed_lt: begin
        cond_holds = (sign_lt == 1'h1);
      end
      branch_if_halfcarry_set: begin
        cond_holds = (f.halfcarry == 1'h1);
      end
      branch_if_halfcarry_clear: begin
        cond_holds = (f.halfcarry == 1'h0);
      end
      branch_if_transfer_set: begin
        cond_holds = (f.transfer == 1'h1);
      end
      branch_if_transfer_clear: begin
        cond_holds = (f.transfer == 1'h0);
      end
      branch_if_overflow_set: begin
        cond_holds = (f.overflow == 1'h1);
      end
      branch_if_overflow_clear: begin
        cond_holds = (f.overflow == 1'h0);
      end
      default: begin
        cond_holds = 1'h0; // no branch for the idle code or unused codes
      end
    endcase
  endfunction

  // true for the nine branch kinds this block executes
  function automatic logic is_branch(input branch_kind_t kind);
    case (kind)
      branch_if_positive,
      branch_if_signed_ge,
      branch_if_signed_lt,
      branch_if_halfcarry_set,
      branch_if_halfcarry_clear,
      branch_if_transfer_set,
      branch_if_transfer_clear,
      branch_if_overflow_set,
      branch_if_overflow_clear: is_branch = 1'h1;
      default: begin
        is_branch = 1'h0; // handshake accepted but otherwise ignored
      end
    endcase
  endfunction

  // state and data registers with their next values
  state_t state_reg;
  state_t state_next;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] target_reg;
  logic [PC_W-1:0] target_next;
  branch_result_t result_reg;
  branch_result_t result_next;

  // decode and arithmetic nets
  wire branch_kind_t instr_kind;
  wire logic [DISP_W-1:0] instr_disp;
  wire logic disp_sign;
  wire logic idle;
  wire logic accept;
  wire logic known;
  wire logic taken;
  wire logic [KIND_CODES-1:0] cond_table;
  wire logic [KIND_CODES-1:0] kind_table;
  wire logic [PC_W-1:0] disp_ext;
  wire logic [PC_W-1:0] pc_seq;
  wire logic [PC_W-1:0] pc_jump;

  // fields of the presented instruction
  assign instr_kind = i_instr.kind;
  assign instr_disp = i_instr.disp;
  assign disp_sign = instr_disp[DISP_W-1];

  // every kind code judged against the live flags side by side
  for (genvar code = 0; code < KIND_CODES; code++) begin : g_kind
    assign cond_table[code] = cond_holds(branch_kind_t'(4'(code)), i_flags);
    assign kind_table[code] = is_branch(branch_kind_t'(4'(code)));
  end

  // handshake: a new instruction only while no taken branch is in flight
  assign idle = (state_reg == st_idle);
  assign o_ready = idle && !i_rst;
  assign accept = i_valid && o_ready;

  // the presented kind picks its table entries; flags count only at accept
  assign known = kind_table[instr_kind];
  assign taken = known && cond_table[instr_kind];

  // target arithmetic; the displacement is sign extended, the sum wraps
  assign disp_ext = {{EXT_W{disp_sign}}, instr_disp};
  assign pc_seq = pc_reg + PC_ONE;
  assign pc_jump = pc_reg + disp_ext + PC_ONE;

  // flags are read only; the write strobe toward the status register stays low
  assign o_flags_we = 1'h0;

  // next state, program counter and target
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    target_next = target_reg;
    case (state_reg)
      st_idle: begin
        if (accept && known) begin
          if (taken) begin
            target_next = pc_jump;
            state_next = st_taken;
          end else begin
            pc_next = pc_seq;
          end
        end
      end
      st_taken: begin
        pc_next = target_reg;
        state_next = st_idle;
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  // completion report; a taken branch reports one cycle after the accept edge
  always_comb begin
    result_next = '0;
    if (!idle) begin
      result_next.done = 1'h1;
      result_next.taken = 1'h1;
    end else if (accept && known && !taken) begin
      result_next.done = 1'h1;
    end
  end

  // sequencing state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // program counter; reset restarts execution at the reset address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // target held across the extra cycle of a taken branch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      target_reg <= PC_RESET;
    end else begin
      target_reg <= target_next;
    end
  end

  // completion report register, one cycle per finished branch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_reg <= '0;
    end else begin
      result_reg <= result_next;
    end
  end

  // outputs come straight from flip-flops
  assign o_pc = pc_reg;
  assign o_result = result_reg;

endmodule

/* File: verif/cb_asserts.sv */
`timescale 1ns/1ns
module cb_asserts import cond_branch_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire branch_instr_t i_instr,
  input wire branch_flags_t i_flags,
  input wire logic o_ready,
  input wire logic [PC_W-1:0] o_pc,
  input wire branch_result_t o_result,
  input wire logic o_flags_we
);
  // accepted branch, its kind, flags and taken step
  wire a = i_valid && o_ready && i_instr.kind != branch_none;
  wire [3:0] k = i_instr.kind;
  wire [3:0] f = i_flags;
  wire [PC_W-1:0] s = {{EXT_W{i_instr.disp[DISP_W-1]}}, i_instr.disp} + PC_ONE;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_pos_cond: assert property (a && k == 4'h0 |=> o_ready == $past(f[1])) else $error("pos");
  a_taken_pc: assert property (a ##1 !o_ready |=> o_pc == $past(o_pc, 2) + $past(s, 2)) else $error("pc");
  a_ge_cond: assert property (a && k == 4'h1 |=> o_ready == $past(f[1] ^ f[0])) else $error("ge");
  a_lt_cond: assert property (a && k == 4'h2 |=> o_ready != $past(f[1] ^ f[0])) else $error("lt");
  a_hc_set: assert property (a && k == 4'h3 |=> o_ready != $past(f[3])) else $error("hs");
  a_hc_clear: assert property (a && k == 4'h4 |=> o_ready == $past(f[3])) else $error("hc");
  a_tr_set: assert property (a && k == 4'h5 |=> o_ready != $past(f[2])) else $error("ts");
  a_ov_set: assert property (a && k == 4'h7 |=> o_ready != $past(f[0])) else $error("vs");
  a_tr_clear: assert property (a && k == 4'h6 |=> o_ready == $past(f[2])) else $error("tc");
  a_ov_clear: assert property (a && k == 4'h8 |=> o_ready == $past(f[0])) else $error("vc");
  a_nt_done: assert property (a ##1 o_ready |-> o_result == 2'h2) else $error("nt done");
  a_tk_done: assert property (a ##1 !o_ready |-> o_result == 2'h0 ##1 o_result == 2'h3) else $error("tk done");
endmodule

/* File: verif/fetch_model.sv */
`timescale 1ns/1ns
module fetch_model import cond_branch_pkg::*; (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid = 1'h0,
  output branch_instr_t o_instr = 11'h000,
  output branch_flags_t o_flags = 4'h0
);
  // hold a branch until accepted or for at most eight more cycles, then release it with scrambled flags
  task automatic issue(input branch_instr_t ins, input branch_flags_t fl, output logic ok);
    @(negedge i_clk);
    o_valid = 1'h1;
    o_instr = ins;
    o_flags = fl;
    for (int n = 0; n < 8 && !i_ready; n++) @(negedge i_clk);
    ok = i_ready;
    @(negedge i_clk);
    o_valid = 1'h0;
    o_flags = ~fl;
  endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb import cond_branch_pkg::*;;
  logic i_clk, i_rst, i_valid, o_ready, o_flags_we, ok;
  branch_instr_t i_instr;
  branch_flags_t i_flags;
  branch_result_t o_result;
  logic [PC_W-1:0] o_pc, p;
  int miscompares = 0, checks_done = 0;
  cond_branch_eval i_cond_branch_eval(.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_instr(i_instr),
    .i_flags(i_flags), .o_ready(o_ready), .o_pc(o_pc), .o_result(o_result), .o_flags_we(o_flags_we));
  fetch_model i_fetch_model(.i_clk(i_clk), .i_ready(o_ready), .o_valid(i_valid), .o_instr(i_instr), .o_flags(i_flags));
  // core clock
  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // reset holds the block idle at pc zero
  task automatic s_reset();
    i_rst = 1'h1;
    repeat (8) @(negedge i_clk);
    chk(o_ready, 1'h0);
    chk(o_pc, 12'h000);
    i_rst = 1'h0;
    p = 12'h000;
  endtask
  // every kind against every flag pattern, pc followed through wraps
  task automatic s_sweep();
    logic [6:0] d;
    logic [9:0] m;
    for (int k = 0; k < 10; k++) begin
      for (int f = 0; f < 16; f++) begin
        d = 7'(k * 13 + f * 9);
        m = {1'h0, !f[0], f[0], !f[2], f[2], !f[3], f[3], f[1] ^ f[0], !(f[1] ^ f[0]), !f[1]};
        i_fetch_model.issue({4'(k), d}, 4'(f), ok);
        chk(ok, 1'h1);
        if (!ok) summarize();
        chk(o_flags_we, 1'h0);
        if (k == 9) begin
          chk(o_result, 2'h0);
          chk(o_pc, p);
        end else if (!m[k]) begin
          p = p + 12'h001;
          chk(o_pc, p);
          chk(o_result, 2'h2);
        end else begin
          chk(o_ready, 1'h0);
          chk(o_result, 2'h0);
          chk(o_pc, p);
          @(negedge i_clk);
          p = p + {{5{d[6]}}, d} + 12'h001;
          chk(o_pc, p);
          chk(o_result, 2'h3);
        end
      end
    end
  endtask
  // main sequence
  initial begin
    s_reset();
    s_sweep();
    s_reset();
    s_sweep();
    summarize();
  end
endmodule
bind cond_branch_eval cb_asserts i_cb_asserts(.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_instr(i_instr),
  .i_flags(i_flags), .o_ready(o_ready), .o_pc(o_pc), .o_result(o_result), .o_flags_we(o_flags_we));
